// *** rtl/stig_gate.sv ***
/*
 * Thread initiation gate of one thread-spawning pipeline stage, with its
 * APB register port. The stage kind and topology are set by software.
 * Assumes all stage-side inputs come from logic on core_clk, and that the
 * dispatcher holds disp_ready only for a request it really takes.
 */
// Operation
// RULE_01: Request only with inputs buffered and resources checked
// RULE_02: Build thread input first, then submit request
// RULE_03: Dispatcher launches thread when execution unit frees
// RULE_04: Thread start order may differ from requests
// RULE_05: Vertex stage pairs vertices; single on flush
// RULE_06: Object stages wait for all object vertices
// RULE_07: Windowing stage launches on demand, no outputs
// RULE_08: Vertex stage needs one output per input
// RULE_09: Geometry and view-volume need one free output
// RULE_10: Setup stage needs one free output entry
// RULE_11: Request only while count below thread limit
// RULE_12: Windowing stage waits for scoreboard clearance
// RULE_13: Strip and fan keep entries one object longer
// RULE_14: Software sizes geometry outputs per topology minimum
// RULE_15: Single thread gets worst-case object entries
// RULE_16: N threads of P entries need N times P
// RULE_17: Software caps threads to fit scratch memory
// RULE_18: Serialized stream output needs thread limit one
// RULE_19: Limit of one at every stage works
// RULE_20: Count up on accept, down on completion
module stig_gate #(
    parameter int CNT_W = 8, // width of thread limit and count
    parameter int OUT_W = 8, // width of free output entry count
    parameter int ADDR_W = 8 // APB address width
) (
    input wire logic core_clk, // pipeline clock, 100 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready_q, // APB ready
    output logic [31:0] prdata_q, // APB read data
    output logic pslverr_q, // APB error, unmapped address
    input wire logic [1:0] in_cnt, // buffered input entries
    input wire logic obj_complete, // whole object buffered
    input wire logic flush_req, // flush or state change pending
    input wire logic raster_demand, // windowing wants a thread
    input wire logic sb_clear, // scoreboard allows a launch
    input wire logic [OUT_W-1:0] out_free, // free output entries
    input wire logic disp_ready, // dispatcher takes request
    input wire logic thread_done, // one thread completed
    output logic disp_req_q, // request to dispatcher
    output logic [1:0] disp_entries_q, // input entries in request
    output logic in_consume_q, // input entries consumed, pulse
    output logic ref_release_q // older object entries free, pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Connected topologies reuse the previous object's vertices
    function automatic logic holds_refs(input stig_pkg::stig_topo_e t);
        holds_refs = (t == stig_pkg::TOPO_LINE_CONN) ||
                     (t == stig_pkg::TOPO_FAN) ||
                     (t == stig_pkg::TOPO_STRIP);
    endfunction : holds_refs

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [stig_pkg::CTRL_W-1:0] ctrl_q;
    logic [CNT_W-1:0] limit_q;
    logic [stig_pkg::ISSUED_W-1:0] issued_q;
    logic held_q;
    stig_pkg::stig_state_e state_q;
    stig_pkg::stig_state_e state_d;
    logic [1:0] gather_q;
    logic [1:0] entries_d;

    stig_cnt_if #(.CNT_W(CNT_W)) cnt_if ();

    stig_thread_ctr #(.CNT_W(CNT_W)) u_ctr (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cnt(cnt_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, write takes effect with pready

    logic acc_first;
    logic acc_done;
    logic wr_en;
    logic hit_ctrl;
    logic hit_limit;
    logic hit_status;
    logic hit_issued;
    logic hit_any;
    logic [31:0] rd_mux;

    assign acc_first = psel && penable && !pready_q;
    assign acc_done = psel && penable && pready_q;
    assign wr_en = acc_done && pwrite;
    assign hit_ctrl = paddr == ADDR_W'(stig_pkg::REG_CTRL);
    assign hit_limit = paddr == ADDR_W'(stig_pkg::REG_LIMIT);
    assign hit_status = paddr == ADDR_W'(stig_pkg::REG_STATUS);
    assign hit_issued = paddr == ADDR_W'(stig_pkg::REG_ISSUED);
    assign hit_any = hit_ctrl || hit_limit || hit_status || hit_issued;

    logic [31:0] status_word;
    assign status_word = 32'(cnt_if.count) |
        (32'(state_q) << stig_pkg::STAT_STATE_LSB) |
        (32'(held_q) << stig_pkg::STAT_HELD_BIT);

    assign rd_mux = hit_ctrl ? 32'(ctrl_q) :
                    hit_limit ? 32'(limit_q) :
                    hit_status ? status_word :
                    hit_issued ? 32'(issued_q) : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc_first;
            prdata_q <= acc_first && !pwrite ? rd_mux : 32'h0000_0000;
            pslverr_q <= acc_first && !hit_any;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_q <= stig_pkg::CTRL_RESET;
            limit_q <= CNT_W'(stig_pkg::LIMIT_RESET); // see RULE_19
        end else begin
            if (wr_en && hit_ctrl) begin
                ctrl_q <= pwdata[stig_pkg::CTRL_W-1:0];
            end
            if (wr_en && hit_limit) begin
                limit_q <= pwdata[CNT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Launch conditions

    logic enable;
    stig_pkg::stig_stage_e stage;
    stig_pkg::stig_topo_e topo;
    logic is_vertex;
    logic is_window;
    logic is_object;
    logic input_ok;
    logic output_ok;
    logic order_ok;
    logic launch;
    logic accept;

    assign enable = ctrl_q[stig_pkg::CTRL_EN_BIT];
    assign stage = stig_pkg::stig_stage_e'(
        ctrl_q[stig_pkg::CTRL_STAGE_LSB +: stig_pkg::STAGE_W]);
    assign topo = stig_pkg::stig_topo_e'(
        ctrl_q[stig_pkg::CTRL_TOPO_LSB +: stig_pkg::TOPO_W]);
    assign is_vertex = stage == stig_pkg::STAGE_VERTEX;
    assign is_window = stage == stig_pkg::STAGE_WINDOW;
    assign is_object = stage == stig_pkg::STAGE_GEOMETRY ||
                       stage == stig_pkg::STAGE_VIEWVOL ||
                       stage == stig_pkg::STAGE_SETUP;

    // A pair normally; a lone vertex only when a flush forces it
    assign entries_d = in_cnt >= stig_pkg::PAIR_ENTRIES ?
                       stig_pkg::PAIR_ENTRIES : stig_pkg::SINGLE_ENTRY;

    assign input_ok = is_vertex ? (in_cnt >= stig_pkg::PAIR_ENTRIES ||
                                   (in_cnt != 2'h0 && flush_req)) : // see RULE_05
                      is_object ? obj_complete : // see RULE_06
                      is_window ? raster_demand : 1'b0; // see RULE_07

    // One output per input entry for vertices, one for object stages
    assign output_ok = is_vertex ? out_free >= OUT_W'(entries_d) : // see RULE_08
                       is_object ? out_free != '0 : // see RULE_09 RULE_10
                       is_window; // see RULE_07

    assign order_ok = !is_window || sb_clear; // see RULE_12

    assign launch = enable && state_q == stig_pkg::ST_IDLE && input_ok &&
                    output_ok && order_ok && cnt_if.below; // see RULE_01 RULE_11
    assign accept = disp_req_q && disp_ready;

    assign cnt_if.inc = accept; // see RULE_20
    assign cnt_if.dec = thread_done; // see RULE_20
    assign cnt_if.limit = limit_q;

    ////////////////////////////////////////////////////////////////////////
    // Request sequencing: gather payload, then hold request until taken

    always_comb begin
        state_d = state_q;
        case (state_q)
            stig_pkg::ST_IDLE: begin
                if (launch) begin
                    state_d = stig_pkg::ST_GATHER;
                end
            end
            stig_pkg::ST_GATHER: begin
                if (gather_q == 2'(stig_pkg::GATHER_CYCLES - 1)) begin
                    state_d = stig_pkg::ST_SUBMIT; // see RULE_02
                end
            end
            stig_pkg::ST_SUBMIT: begin
                if (disp_ready) begin
                    state_d = stig_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = stig_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q <= stig_pkg::ST_IDLE;
            gather_q <= 2'h0;
            disp_entries_q <= 2'h0;
        end else begin
            state_q <= state_d;
            gather_q <= state_q == stig_pkg::ST_GATHER ?
                        gather_q + 2'h1 : 2'h0;
            if (launch) begin
                disp_entries_q <= is_vertex ? entries_d : 2'h0;
            end
        end
    end

    // The dispatcher may start these in any order; nothing here waits
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            disp_req_q <= 1'b0;
            in_consume_q <= 1'b0;
            issued_q <= '0;
        end else begin
            disp_req_q <= state_d == stig_pkg::ST_SUBMIT; // see RULE_02 RULE_04
            in_consume_q <= accept;
            if (accept) begin
                issued_q <= issued_q + stig_pkg::ISSUED_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference release of stage entries; view-volume stage holds one object longer in connected topologies

    logic keep_refs;
    assign keep_refs = stage == stig_pkg::STAGE_VIEWVOL && holds_refs(topo);

    // In connected topologies the first finished object is held; later ones free the older one
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            held_q <= 1'b0;
            ref_release_q <= 1'b0;
        end else begin
            ref_release_q <= thread_done && (!keep_refs || held_q); // see RULE_13
            if (flush_req && !thread_done) begin
                held_q <= 1'b0;
            end else if (thread_done && keep_refs) begin
                held_q <= 1'b1; // see RULE_13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_gather;
        state_q == stig_pkg::ST_GATHER [*2];
    endsequence

    sequence s_submit;
        disp_req_q && state_q == stig_pkg::ST_SUBMIT;
    endsequence

    logic idle_en;
    assign idle_en = enable && state_q == stig_pkg::ST_IDLE;

    a_launch_order: assert property ( // see RULE_01 RULE_02
        launch |=> s_gather ##1 s_submit
    ) else $error("launch did not gather then submit");

    a_req_held: assert property ( // see RULE_02
        disp_req_q && !disp_ready |=> disp_req_q && $stable(disp_entries_q)
    ) else $error("request dropped before dispatcher took it");

    a_vertex_pair: assert property ( // see RULE_05
        idle_en && is_vertex && in_cnt == 2'h1 && !flush_req
        |=> state_q == stig_pkg::ST_IDLE
    ) else $error("lone vertex launched without flush");

    a_object_wait: assert property ( // see RULE_06
        idle_en && is_object && !obj_complete |=> state_q == stig_pkg::ST_IDLE
    ) else $error("object thread launched before vertices buffered");

    a_window_demand: assert property ( // see RULE_07
        idle_en && is_window && raster_demand && sb_clear && cnt_if.below
        |=> state_q == stig_pkg::ST_GATHER
    ) else $error("windowing launch blocked without cause");

    a_vertex_space: assert property ( // see RULE_08
        idle_en && is_vertex && in_cnt >= 2'h2 && out_free < OUT_W'(2)
        |=> state_q == stig_pkg::ST_IDLE
    ) else $error("vertex pair launched without two outputs");

    a_object_space: assert property ( // see RULE_09 RULE_10
        idle_en && is_object && out_free == '0 |=> state_q == stig_pkg::ST_IDLE
    ) else $error("object thread launched without free output");

    a_limit_block: assert property ( // see RULE_11
        idle_en && cnt_if.count >= limit_q |=> state_q == stig_pkg::ST_IDLE
    ) else $error("launch at or above thread limit");

    a_scoreboard: assert property ( // see RULE_12
        idle_en && is_window && !sb_clear |=> state_q == stig_pkg::ST_IDLE
    ) else $error("windowing launch while scoreboard blocks");

    a_hold_first: assert property ( // see RULE_13
        thread_done && keep_refs && !held_q |=> !ref_release_q && held_q
    ) else $error("first connected object released too early");

    a_count_step: assert property ( // see RULE_20
        accept && !thread_done && !(&cnt_if.count)
        |=> cnt_if.count == $past(cnt_if.count) + CNT_W'(1)
    ) else $error("count not raised on accept");

endmodule : stig_gate

// *** rtl/stig_pkg.sv ***
/*
 * Shared constants and types of the stage thread initiation gate.
 * Assumes one pipeline clock and an APB register port with 32-bit data.
 */
package stig_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LIMIT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ISSUED = 8'h0c;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_STAGE_LSB = 1;
    localparam int STAGE_W = 3;
    localparam int CTRL_TOPO_LSB = 4;
    localparam int TOPO_W = 2;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Status register fields
    localparam int STAT_STATE_LSB = 16;
    localparam int STAT_HELD_BIT = 20;

    // Thread limit of one is always a safe start
    localparam int LIMIT_RESET = 1;

    // Cycles spent building thread input data before submission
    localparam int GATHER_CYCLES = 2;
    localparam int ISSUED_W = 16;

    // Vertex pair and single vertex entry counts
    localparam logic [1:0] PAIR_ENTRIES = 2'h2;
    localparam logic [1:0] SINGLE_ENTRY = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        STAGE_VERTEX,
        STAGE_GEOMETRY,
        STAGE_VIEWVOL,
        STAGE_SETUP,
        STAGE_WINDOW
    } stig_stage_e;

    typedef enum logic [1:0] {
        TOPO_LIST,
        TOPO_LINE_CONN,
        TOPO_FAN,
        TOPO_STRIP
    } stig_topo_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_GATHER,
        ST_SUBMIT
    } stig_state_e;

endpackage : stig_pkg

// *** rtl/stig_cnt_if.sv ***
/*
 * Carrier between the gate and its concurrent thread counter.
 * Assumes both ends run on the same pipeline clock.
 */
interface stig_cnt_if #(
    parameter int CNT_W = 8
);
    logic inc;
    logic dec;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] count;
    logic below;

    modport ctr (input inc, input dec, input limit,
                 output count, output below);
    modport user (output inc, output dec, output limit,
                  input count, input below);
endinterface : stig_cnt_if

// *** rtl/stig_thread_ctr.sv ***
/*
 * Concurrent thread counter with limit compare.
 * Assumes inc and dec are single-cycle pulses on the pipeline clock.
 */
module stig_thread_ctr #(
    parameter int CNT_W = 8
) (
    input wire logic core_clk, // pipeline clock
    input wire logic rst_b, // synchronous reset, active low
    stig_cnt_if.ctr cnt // counter requests and result
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic at_max;

    assign at_max = &count_q;

    // Completions may come in any order, so only the total matters
    always_comb begin
        count_d = count_q;
        if (cnt.inc && !cnt.dec && !at_max) begin
            count_d = count_q + CNT_W'(1); // see RULE_20
        end else if (cnt.dec && !cnt.inc && count_q != '0) begin
            count_d = count_q - CNT_W'(1); // see RULE_04
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign cnt.count = count_q;
    assign cnt.below = count_q < cnt.limit; // see RULE_11

endmodule : stig_thread_ctr

// *** verification/stig_disp_model.sv ***
/*
 * Behavioural thread dispatcher facing the gate: takes requests, runs them.
 * Assumes one clock; the bench sets the accept latency and the run length.
 */
module stig_disp_model (
    input wire logic core_clk, // pipeline clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic disp_req_q, // request from the gate
    input wire logic [3:0] lat, // wait cycles before taking
    input wire logic [7:0] run, // thread run length, at least 1
    output logic disp_ready, // request taken at this edge
    output logic thread_done // one thread finished, pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    logic odd_q;
    logic [7:0] tmr_q [4];
    logic fin;
    logic put;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        disp_ready <= 1'b0;
        thread_done <= 1'b0;
        fin = 1'b0;
        put = 1'b0;
        if (!rst_b) begin
            wait_q <= 4'h0;
            odd_q <= 1'b0;
            foreach (tmr_q[i]) tmr_q[i] <= 8'h00;
        end else begin
            // Takes after lat cycles, whether or not a unit is free
            if (disp_req_q && !disp_ready) begin
                disp_ready <= (wait_q >= lat);
                wait_q <= (wait_q >= lat) ? 4'h0 : wait_q + 4'h1;
            end
            // One completion per cycle; a blocked slot retries
            for (int i = 0; i < 4; i++) begin
                if (tmr_q[i] == 8'h01 && !fin) begin
                    thread_done <= 1'b1;
                    fin = 1'b1;
                    tmr_q[i] <= 8'h00;
                end else if (tmr_q[i] > 8'h01) begin
                    tmr_q[i] <= tmr_q[i] - 8'h01;
                end
            end
            // Every other thread runs shorter, so finish order flips
            if (disp_req_q && disp_ready) begin
                odd_q <= !odd_q;
                for (int i = 0; i < 4; i++) begin
                    if (tmr_q[i] == 8'h00 && !put) begin
                        tmr_q[i] <= odd_q ? (run >> 1) + 8'h01 : run;
                        put = 1'b1;
                    end
                end
            end
        end
    end
endmodule : stig_disp_model

// *** verification/stage_thread_initiation_gate_bench.sv ***
/*
 * Self-checking bench of the thread initiation gate and its APB port.
 * Assumes the dispatcher model beside it and a 100 MHz core_clk.
 */
module stage_thread_initiation_gate_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_q, rd;
    logic pready_q, pslverr_q, err;
    logic [1:0] in_cnt = 2'h0, disp_entries_q;
    logic obj_complete = 1'b0, flush_req = 1'b0;
    logic raster_demand = 1'b0, sb_clear = 1'b0;
    logic [7:0] out_free = 8'h00, run = 8'h06;
    logic [3:0] lat = 4'h0;
    logic disp_ready, thread_done, disp_req_q, in_consume_q, ref_release_q;
    int mismatches = 0, n_compared = 0;
    int n_acc = 0, n_done = 0, n_rel = 0, n_con = 0;

    always #5 core_clk = ~core_clk;

    stig_gate dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready_q(pready_q), .prdata_q(prdata_q), .pslverr_q(pslverr_q),
        .in_cnt(in_cnt), .obj_complete(obj_complete), .flush_req(flush_req),
        .raster_demand(raster_demand), .sb_clear(sb_clear),
        .out_free(out_free), .disp_ready(disp_ready),
        .thread_done(thread_done), .disp_req_q(disp_req_q),
        .disp_entries_q(disp_entries_q), .in_consume_q(in_consume_q),
        .ref_release_q(ref_release_q));
    stig_disp_model partner (.core_clk(core_clk), .rst_b(rst_b),
        .disp_req_q(disp_req_q), .lat(lat), .run(run),
        .disp_ready(disp_ready), .thread_done(thread_done));

    always @(posedge core_clk) begin
        if (disp_req_q === 1'b1 && disp_ready === 1'b1)
            n_acc++;
        if (thread_done === 1'b1)
            n_done++;
        if (ref_release_q === 1'b1)
            n_rel++;
        if (in_consume_q === 1'b1)
            n_con++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready_q === 1'b1)
                break;
        end
        chk(k < 20, "no APB ready");
        if (k == 20)
            end_of_test();
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic cfg(input int st, input int tp, input int lim);
        apb(1'b1, stig_pkg::REG_LIMIT, 32'(lim));
        apb(1'b1, stig_pkg::REG_CTRL, 32'((1 << stig_pkg::CTRL_EN_BIT) |
            (st << stig_pkg::CTRL_STAGE_LSB) |
            (tp << stig_pkg::CTRL_TOPO_LSB)));
    endtask : cfg

    task automatic set_in(input logic [1:0] ic, input logic ob, fl, rq, sb,
                          input logic [7:0] of);
        in_cnt <= ic;
        obj_complete <= ob;
        flush_req <= fl;
        raster_demand <= rq;
        sb_clear <= sb;
        out_free <= of;
        @(posedge core_clk);
    endtask : set_in

    // Idle means every taken thread has also completed
    task automatic wait_idle;
        int k;
        for (k = 0; k < 600; k++) begin
            @(posedge core_clk);
            if (n_done == n_acc && disp_req_q === 1'b0)
                break;
        end
        if (k == 600) begin
            mismatches++;
            end_of_test();
        end
        repeat (6) @(posedge core_clk);
    endtask : wait_idle

    // Inputs drop as soon as the request shows, so one thread at most
    task automatic try(input logic [1:0] ic, input logic ob, fl, rq, sb,
                       input logic [7:0] of, input bit exp,
                       input logic [1:0] ent);
        int k;
        int c0;
        c0 = n_con;
        set_in(ic, ob, fl, rq, sb, of);
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (disp_req_q === 1'b1)
                break;
        end
        set_in(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        chk((k < 20) == exp, "request presence");
        if (k < 20) begin
            chk(disp_entries_q === ent, "entry count");
            chk(k == stig_pkg::GATHER_CYCLES, "gather time");
        end
        wait_idle();
        chk(n_con - c0 == int'(exp), "consume pulses");
    endtask : try
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, stig_pkg::REG_CTRL, 32'h0);
        chk(rd === 32'h0 && err === 1'b0, "control reset");
        apb(1'b0, stig_pkg::REG_LIMIT, 32'h0);
        chk(rd === 32'h1, "limit reset");
        apb(1'b1, 8'h10, 32'hffff_ffff);
        chk(err === 1'b1, "unmapped write");
        apb(1'b0, 8'h10, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, stig_pkg::REG_LIMIT, 32'h5);
        apb(1'b0, stig_pkg::REG_LIMIT, 32'h0);
        chk(rd === 32'h5, "limit readback");
    endtask : t_regs

    task automatic t_vertex;
        cfg(0, 0, 2);
        try(2'h2, 0, 0, 0, 0, 8'h02, 1, 2'h2);
        try(2'h1, 0, 0, 0, 0, 8'h02, 0, 2'h0);
        try(2'h1, 0, 1, 0, 0, 8'h01, 1, 2'h1);
        try(2'h2, 0, 0, 0, 0, 8'h01, 0, 2'h0);
        try(2'h0, 0, 1, 0, 0, 8'h02, 0, 2'h0);
    endtask : t_vertex

    task automatic t_object;
        for (int st = 1; st < 4; st++) begin
            cfg(st, 0, 2);
            try(2'h0, 0, 0, 0, 0, 8'h04, 0, 2'h0);
            try(2'h0, 1, 0, 0, 0, 8'h00, 0, 2'h0);
            try(2'h0, 1, 0, 0, 0, 8'h01, 1, 2'h0);
        end
    endtask : t_object

    task automatic t_window;
        lat <= 4'h3;
        cfg(4, 0, 2);
        try(2'h0, 0, 0, 1, 0, 8'h00, 0, 2'h0);
        try(2'h0, 0, 0, 0, 1, 8'h00, 0, 2'h0);
        try(2'h0, 0, 0, 1, 1, 8'h00, 1, 2'h0);
        lat <= 4'h0;
    endtask : t_window

    task automatic t_limit;
        int a0;
        run <= 8'hc8;
        for (int lim = 0; lim < 4; lim++) begin
            cfg(1, 0, lim);
            a0 = n_acc;
            set_in(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h08);
            repeat (60) @(posedge core_clk);
            chk(n_acc - a0 == lim, "threads above limit");
            apb(1'b0, stig_pkg::REG_STATUS, 32'h0);
            chk(rd[7:0] === 8'(lim), "live count");
            set_in(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
            wait_idle();
            apb(1'b0, stig_pkg::REG_STATUS, 32'h0);
            chk(rd[7:0] === 8'h00, "count after done");
        end
        run <= 8'h06;
    endtask : t_limit

    // Limit of one: the second thread needs the first one's decrement
    task automatic t_release;
        int r0;
        int h;
        for (int st = 1; st < 3; st++) begin
            for (int tp = 0; tp < 4; tp += 3) begin
                cfg(st, tp, 1);
                h = int'(st == 2 && tp != 0);
                r0 = n_rel;
                try(2'h0, 1, 0, 0, 0, 8'h08, 1, 2'h0);
                chk(n_rel - r0 == 1 - h, "first release");
                apb(1'b0, stig_pkg::REG_STATUS, 32'h0);
                chk(rd[20] === 1'(h), "held flag");
                try(2'h0, 1, 0, 0, 0, 8'h08, 1, 2'h0);
                chk(n_rel - r0 == 2 - h, "second release");
            end
        end
        // Eight threads were taken since the last reset
        apb(1'b0, stig_pkg::REG_ISSUED, 32'h0);
        chk(rd === 32'h8, "accepted total");
    endtask : t_release
    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
    endtask : do_reset

    initial begin
        do_reset();
        t_regs();
        t_vertex();
        t_object();
        t_window();
        t_limit();
        do_reset();
        t_release();
        end_of_test();
    end
endmodule : stage_thread_initiation_gate_bench
